// ===== rtl/ubrt_core.sv
// Serial channel core: baud generator, receiver with status, transmitter
// with gap insertion, and a plain register port.
// Assumes one clock; serial pins are asynchronous and synchronised here.
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "ubrt_consts.svh"

module ubrt_core
  import ubrt_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic RXD_I,
  output logic TXD_O,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_O
);

  // Elaboration check on divisor width
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must lie in 2..16");
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Check bit for the low n data bits
  function automatic logic check_bit(input logic [7:0] data,
                                     input logic [1:0] len,
                                     input logic [2:0] kind);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 5 + int'(len)) begin
        acc = acc ^ data[i];
      end
    end
    case (kind[1:0])
      2'h0: check_bit = acc;
      2'h1: check_bit = ~acc;
      2'h2: check_bit = 1'b0;
      default: check_bit = 1'b1;
    endcase
  endfunction : check_bit

  // Bits after the start bit, LSB first, stop bits padded with ones
  function automatic logic [10:0] frame_bits(input logic [7:0] data,
                                             input logic [1:0] len,
                                             input logic [2:0] kind);
    logic [10:0] v;
    v = 11'h7FF;
    for (int i = 0; i < 8; i++) begin
      if (i < 5 + int'(len)) begin
        v[i] = data[i];
      end
    end
    if (!kind[2]) begin
      v[5 + len] = check_bit(data, len, kind);
    end
    frame_bits = v;
  endfunction : frame_bits

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [31:0] mode_reg;
  logic [DIV_W-1:0] baud_divisor_reg;
  logic [7:0] receive_idle_limit_reg;
  logic [7:0] transmit_gap_reg;
  logic [7:0] receive_holding_reg;
  logic [7:0] transmit_holding_reg;
  logic receive_holding_full, overrun_flag, check_bit_error_flag;
  logic frame_flag, idle_timeout_flag, transmit_holding_full;
  logic [1:0] clock_source_select, character_length_field, stop_count_field;
  logic [2:0] check_bit_type;
  logic clocked_mode, clock_pin_drive_enable, transmit_all_idle;
  logic wr_ctrl, wr_thr, rd_rhr, clear_status, rearm_idle_timer_cmd;

  assign clock_source_select = mode_reg[`UBRT_MODE_CLKSRC_LO +: 2];
  assign character_length_field = mode_reg[`UBRT_MODE_LEN_LO +: 2];
  assign check_bit_type = mode_reg[`UBRT_MODE_CHECK_LO +: 3];
  assign stop_count_field = mode_reg[`UBRT_MODE_STOP_LO +: 2];
  assign clocked_mode = mode_reg[`UBRT_MODE_CLOCKED];
  assign clock_pin_drive_enable = mode_reg[`UBRT_MODE_PIN_DRIVE];

  assign wr_ctrl = WR_I && ADDR_I == `UBRT_OFS_CTRL;
  assign wr_thr = WR_I && ADDR_I == `UBRT_OFS_TXHOLD;
  assign rd_rhr = RD_I && ADDR_I == `UBRT_OFS_RXHOLD;
  assign clear_status = wr_ctrl && WDATA_I[`UBRT_CMD_CLR_STATUS];
  assign rearm_idle_timer_cmd = wr_ctrl && WDATA_I[`UBRT_CMD_REARM_IDLE];

  // Configuration writes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_reg <= `UBRT_RST_MODE;
      baud_divisor_reg <= DIV_W'(`UBRT_RST_DIVISOR);
      receive_idle_limit_reg <= `UBRT_RST_IDLELIM;
      transmit_gap_reg <= `UBRT_RST_GAP;
    end else if (WR_I) begin
      case (ADDR_I)
        `UBRT_OFS_MODE: mode_reg <= WDATA_I & `UBRT_MODE_MASK;
        `UBRT_OFS_DIVISOR: baud_divisor_reg <= WDATA_I[DIV_W-1:0];
        `UBRT_OFS_IDLELIM: receive_idle_limit_reg <= WDATA_I[7:0];
        `UBRT_OFS_GAP: transmit_gap_reg <= WDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (!RD_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      case (ADDR_I)
        `UBRT_OFS_MODE: RDATA_O <= mode_reg;
        `UBRT_OFS_DIVISOR: RDATA_O <= 32'(baud_divisor_reg);
        `UBRT_OFS_IDLELIM: RDATA_O <= {24'h000000, receive_idle_limit_reg};
        `UBRT_OFS_GAP: RDATA_O <= {24'h000000, transmit_gap_reg};
        `UBRT_OFS_RXHOLD: RDATA_O <= {24'h000000, receive_holding_reg};
        `UBRT_OFS_FLAGS: begin
          RDATA_O <= 32'h0000_0000;
          RDATA_O[`UBRT_FLG_RXFULL] <= receive_holding_full;
          RDATA_O[`UBRT_FLG_TXFREE] <= ~transmit_holding_full;
          RDATA_O[`UBRT_FLG_OVERRUN] <= overrun_flag;
          RDATA_O[`UBRT_FLG_FRAME] <= frame_flag;
          RDATA_O[`UBRT_FLG_CHECK] <= check_bit_error_flag;
          RDATA_O[`UBRT_FLG_IDLE_TO] <= idle_timeout_flag;
          RDATA_O[`UBRT_FLG_TXIDLE] <= transmit_all_idle;
        end
        default: RDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  logic [2:0] rxd_sync, sclk_sync;
  logic rx_level, sclk_level_in, sclk_prev;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rxd_sync <= 3'h7;
      sclk_sync <= 3'h0;
      rx_level <= 1'b1;
      sclk_level_in <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      rxd_sync <= {rxd_sync[1:0], RXD_I};
      sclk_sync <= {sclk_sync[1:0], SCLK_I};
      if (rxd_sync[1] == rxd_sync[2]) begin
        rx_level <= rxd_sync[2];
      end
      if (sclk_sync[1] == sclk_sync[2]) begin
        sclk_level_in <= sclk_sync[2];
      end
      sclk_prev <= sclk_level_in;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_level_in && !sclk_prev;
  assign sclk_fall = !sclk_level_in && sclk_prev;

  ////////////////////////////////////////////////////////////////////////
  // Baud generator

  logic [2:0] prescale;
  logic [DIV_W-1:0] div_cnt, half_point;
  logic [3:0] ovs_phase;
  logic src_tick, div_on, div_wrap, ovs_tick, bit_tick;
  logic rise_tick, fall_tick, tx_tick, period_tick, ext_src, sclk_level;

  assign ext_src = clock_source_select[1];
  assign div_on = baud_divisor_reg != '0;
  assign half_point = baud_divisor_reg >> 1;

  always_comb begin
    unique case (clock_source_select)
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = prescale == `UBRT_PRESCALE_LAST;
      default: src_tick = sclk_rise;
    endcase
  end

  assign div_wrap = src_tick && div_on &&
                    div_cnt >= baud_divisor_reg - DIV_W'(1);
  assign ovs_tick = !clocked_mode && div_wrap;
  assign bit_tick = ovs_tick && ovs_phase == `UBRT_OVS_LAST;

  // internal clocked mode; external pin used undivided
  always_comb begin
    if (clocked_mode && ext_src) begin
      rise_tick = sclk_rise;
      fall_tick = sclk_fall;
    end else if (clocked_mode) begin
      rise_tick = div_wrap;
      fall_tick = src_tick && div_on && div_cnt ==
                  ((half_point == '0) ? '0 : half_point - DIV_W'(1));
    end else begin
      rise_tick = 1'b0;
      fall_tick = 1'b0;
    end
  end

  // transmitter moves on the falling edge of the bit clock when clocked, on bit_tick otherwise
  assign tx_tick = clocked_mode ? fall_tick : bit_tick;
  assign period_tick = clocked_mode ? rise_tick : bit_tick;

  // Prescaler, divider and oversample phase
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prescale <= 3'h0;
      div_cnt <= '0;
      ovs_phase <= 4'h0;
    end else begin
      prescale <= prescale + 3'h1;
      if (!div_on) begin
        div_cnt <= '0;
      end else if (div_wrap) begin
        div_cnt <= '0;
      end else if (src_tick) begin
        div_cnt <= div_cnt + DIV_W'(1);
      end
      if (ovs_tick) begin
        ovs_phase <= ovs_phase + 4'h1;
      end
    end
  end

  // Bit clock level driven out on the pin
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_level <= 1'b0;
    end else if (!clocked_mode) begin
      sclk_level <= ~ovs_phase[3];
    end else if (rise_tick) begin
      sclk_level <= 1'b1;
    end else if (fall_tick) begin
      sclk_level <= 1'b0;
    end
  end

  assign SCLK_OE_O = !ext_src && clock_pin_drive_enable;
  assign SCLK_O = sclk_level;

  ////////////////////////////////////////////////////////////////////////
  // Receiver

  ubrt_rx_state_t rx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_data;
  logic rx_check, rx_sample, rx_done;

  // mid-bit sample in asynchronous mode; rising edge when clocked
  assign rx_sample = clocked_mode ? rise_tick :
                     (ovs_tick && rx_cnt == `UBRT_OVS_LAST);
  assign rx_done = rx_state == UBRT_RX_STOP && rx_sample;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_state <= UBRT_RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bit <= 3'h0;
      rx_data <= 8'h00;
      rx_check <= 1'b0;
    end else begin
      if (rx_state != UBRT_RX_IDLE && ovs_tick) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      unique case (rx_state)
        UBRT_RX_IDLE: begin
          rx_bit <= 3'h0;
          rx_data <= 8'h00;
          if (clocked_mode) begin
            rx_cnt <= 4'h0;
            // low sample on rising edge is a start
            if (rise_tick && !rx_level) begin
              rx_state <= UBRT_RX_DATA;
            end
          end else if (ovs_tick) begin
            // start needs more than seven low ticks
            if (rx_level) begin
              rx_cnt <= 4'h0;
            end else if (rx_cnt == `UBRT_START_LOW_LAST) begin
              rx_cnt <= 4'h0;
              rx_state <= UBRT_RX_DATA;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        UBRT_RX_DATA: begin
          if (rx_sample) begin
            rx_data[rx_bit] <= rx_level;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'(3'h4 + 3'(character_length_field))) begin
              rx_state <= check_bit_type[2] ? UBRT_RX_STOP : UBRT_RX_CHECK;
            end
          end
        end
        UBRT_RX_CHECK: begin
          if (rx_sample) begin
            rx_check <= rx_level;
            rx_state <= UBRT_RX_STOP;
          end
        end
        UBRT_RX_STOP: begin
          if (rx_sample) begin
            rx_state <= UBRT_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive flags: a hardware set wins over a software clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      receive_holding_reg <= 8'h00;
      receive_holding_full <= 1'b0;
      overrun_flag <= 1'b0;
      check_bit_error_flag <= 1'b0;
      frame_flag <= 1'b0;
    end else begin
      if (rx_done) begin
        receive_holding_reg <= rx_data;
        receive_holding_full <= 1'b1;
      end else if (rd_rhr) begin
        receive_holding_full <= 1'b0;
      end
      if (rx_done && receive_holding_full && !rd_rhr) begin
        overrun_flag <= 1'b1;
      end else if (clear_status) begin
        overrun_flag <= 1'b0;
      end
      if (rx_done && !check_bit_type[2]) begin
        check_bit_error_flag <= rx_check !=
          check_bit(rx_data, character_length_field, check_bit_type);
      end else if (rd_rhr) begin
        check_bit_error_flag <= 1'b0;
      end
      // low stop with a data bit high
      if (rx_done && !rx_level && rx_data != 8'h00) begin
        frame_flag <= 1'b1;
      end else if (clear_status) begin
        frame_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle time-out

  logic [9:0] idle_cnt;
  logic idle_run;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      idle_cnt <= 10'h000;
      idle_run <= 1'b0;
      idle_timeout_flag <= 1'b0;
    end else begin
      if (receive_idle_limit_reg == 8'h00) begin
        idle_run <= 1'b0;
      end else if (rx_done) begin
        // limit times four bit periods, reloaded per byte
        idle_cnt <= {receive_idle_limit_reg, 2'h0};
        idle_run <= 1'b1;
      end else if (rearm_idle_timer_cmd) begin
        // back to waiting for a first character
        idle_run <= 1'b0;
      end else if (idle_run && period_tick) begin
        idle_cnt <= idle_cnt - 10'h001;
        if (idle_cnt == 10'h001) begin
          idle_run <= 1'b0;
        end
      end
      if (idle_run && period_tick && idle_cnt == 10'h001 && !rx_done &&
          receive_idle_limit_reg != 8'h00) begin
        idle_timeout_flag <= 1'b1;
      end else if (rearm_idle_timer_cmd || clear_status) begin
        idle_timeout_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  ubrt_tx_state_t tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic [7:0] gap_cnt;
  logic tx_slot, tx_load;
  logic [3:0] frame_len;

  // length, check bit and stop count from mode fields
  assign frame_len = 4'h5 + 4'(character_length_field) +
                     (check_bit_type[2] ? 4'h0 : 4'h1) +
                     (stop_count_field == 2'h0 ? 4'h1 : 4'h2);

  // Shifter free at this tick once stop bits and gap are done
  always_comb begin
    unique case (tx_state)
      UBRT_TX_IDLE: tx_slot = 1'b1;
      UBRT_TX_SHIFT: tx_slot = tx_left == 4'h0 && transmit_gap_reg == 8'h00;
      UBRT_TX_GAP: tx_slot = gap_cnt == 8'h01;
    endcase
  end
  // holding word moves at the first tick after stop bits and gap
  assign tx_load = tx_tick && tx_slot && transmit_holding_full;
  assign transmit_all_idle = !transmit_holding_full &&
                             tx_state == UBRT_TX_IDLE;

  // Holding register: a new write wins over the transfer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      transmit_holding_reg <= 8'h00;
      transmit_holding_full <= 1'b0;
    end else if (wr_thr) begin
      transmit_holding_reg <= WDATA_I[7:0];
      transmit_holding_full <= 1'b1;
    end else if (tx_load) begin
      // free flag set at the transfer
      transmit_holding_full <= 1'b0;
    end
  end

  // Shifter and gap sequence
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_state <= UBRT_TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      gap_cnt <= 8'h00;
      TXD_O <= 1'b1;
    end else if (tx_tick) begin
      if (tx_load) begin
        // start bit first, then LSB-first payload
        TXD_O <= 1'b0;
        tx_shift <= frame_bits(transmit_holding_reg,
                               character_length_field, check_bit_type);
        tx_left <= frame_len;
        tx_state <= UBRT_TX_SHIFT;
      end else begin
        unique case (tx_state)
          UBRT_TX_IDLE: TXD_O <= 1'b1;
          UBRT_TX_SHIFT: begin
            if (tx_left != 4'h0) begin
              TXD_O <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_left <= tx_left - 4'h1;
            end else if (transmit_gap_reg != 8'h00) begin
              // hold line high for the gap
              TXD_O <= 1'b1;
              gap_cnt <= transmit_gap_reg;
              tx_state <= UBRT_TX_GAP;
            end else begin
              TXD_O <= 1'b1;
              tx_state <= UBRT_TX_IDLE;
            end
          end
          UBRT_TX_GAP: begin
            TXD_O <= 1'b1;
            gap_cnt <= gap_cnt - 8'h01;
            if (gap_cnt == 8'h01) begin
              tx_state <= UBRT_TX_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule : ubrt_core

// ===== include/ubrt_consts.svh
// Offsets, field positions, reset values and timing counts of the
// serial channel core. Assumes byte addresses on a 6-bit register port.
`ifndef UBRT_CONSTS_SVH
`define UBRT_CONSTS_SVH

// Register offsets
`define UBRT_OFS_CTRL 6'h00
`define UBRT_OFS_MODE 6'h04
`define UBRT_OFS_FLAGS 6'h14
`define UBRT_OFS_RXHOLD 6'h18
`define UBRT_OFS_TXHOLD 6'h1C
`define UBRT_OFS_DIVISOR 6'h20
`define UBRT_OFS_IDLELIM 6'h24
`define UBRT_OFS_GAP 6'h28

// Control command bits
`define UBRT_CMD_CLR_STATUS 8
`define UBRT_CMD_REARM_IDLE 11

// Mode register fields
`define UBRT_MODE_LEN_LO 0
`define UBRT_MODE_CLKSRC_LO 4
`define UBRT_MODE_CLOCKED 7
`define UBRT_MODE_CHECK_LO 8
`define UBRT_MODE_STOP_LO 12
`define UBRT_MODE_PIN_DRIVE 18
`define UBRT_MODE_MASK 32'h0004_37B3

// Flag register bits
`define UBRT_FLG_RXFULL 0
`define UBRT_FLG_TXFREE 1
`define UBRT_FLG_OVERRUN 5
`define UBRT_FLG_FRAME 6
`define UBRT_FLG_CHECK 7
`define UBRT_FLG_IDLE_TO 8
`define UBRT_FLG_TXIDLE 9

// Reset values
`define UBRT_RST_MODE 32'h0000_0000
`define UBRT_RST_DIVISOR 16'h0000
`define UBRT_RST_IDLELIM 8'h00
`define UBRT_RST_GAP 8'h00

// Timing counts
`define UBRT_PRESCALE_LAST 3'h7
`define UBRT_OVS_LAST 4'hF
`define UBRT_START_LOW_LAST 4'h7
`define UBRT_IDLE_MULT 2

`endif

// ===== include/ubrt_pkg.sv
// Types of the serial channel core: receiver and transmitter states.
// Assumes nothing beyond a SystemVerilog compiler.
package ubrt_pkg;

  typedef enum logic [3:0] {
    UBRT_RX_IDLE = 4'b0001,
    UBRT_RX_DATA = 4'b0010,
    UBRT_RX_CHECK = 4'b0100,
    UBRT_RX_STOP = 4'b1000
  } ubrt_rx_state_t;

  typedef enum logic [2:0] {
    UBRT_TX_IDLE = 3'b001,
    UBRT_TX_SHIFT = 3'b010,
    UBRT_TX_GAP = 3'b100
  } ubrt_tx_state_t;

endpackage : ubrt_pkg

// ===== dv/ubrt_properties.sv
// Port checker of the serial channel core, bound to ubrt_core.
// Assumes register writes land at the edge that takes them.
`include "ubrt_consts.svh"
module ubrt_props (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic RXD_I,
  input wire logic TXD_O,
  input wire logic SCLK_I,
  input wire logic SCLK_O,
  input wire logic SCLK_OE_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  localparam logic [5:0] FL = `UBRT_OFS_FLAGS;
  logic [31:0] mode;
  logic [15:0] div;
  ////////////////////////////////////////
  // Shadow of the setup software wrote
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode <= 32'h0;
      div <= 16'h0;
    end else if (WR_I && ADDR_I == `UBRT_OFS_MODE) begin
      mode <= WDATA_I;
    end else if (WR_I && ADDR_I == `UBRT_OFS_DIVISOR) begin
      div <= WDATA_I[15:0];
    end
  end
  ////////////////////////////////////////
  property p_pin_dir;
    SCLK_OE_O == (!mode[5] && mode[18]);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin direction wrong");
  property p_quiet;
    (div == 16'h0 && !mode[5]) [*3] |-> $stable(SCLK_O);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bit clock runs at zero divisor");
  property p_div_back;
    RD_I && ADDR_I == `UBRT_OFS_DIVISOR |=> RDATA_O == {16'h0, div};
  endproperty
  a_div_back: assert property (p_div_back)
    else $error("divisor readback wrong");
  property p_idle_free;
    RD_I && ADDR_I == FL |=> !RDATA_O[9] || RDATA_O[1];
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("all idle without free holding");
  property p_thr_busy;
    WR_I && ADDR_I == `UBRT_OFS_TXHOLD ##2 RD_I && ADDR_I == FL
      |=> !RDATA_O[9];
  endproperty
  a_thr_busy: assert property (p_thr_busy)
    else $error("all idle after holding write");
  property p_rx_read;
    RD_I && ADDR_I == `UBRT_OFS_RXHOLD ##2 RD_I && ADDR_I == FL
      |=> RDATA_O[0] == 1'b0 && RDATA_O[7] == 1'b0;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("full or check flag kept after read");
  property p_clr_cmd;
    WR_I && ADDR_I == `UBRT_OFS_CTRL && WDATA_I[8] ##2 RD_I && ADDR_I == FL
      |=> RDATA_O[6:5] == 2'b00;
  endproperty
  a_clr_cmd: assert property (p_clr_cmd)
    else $error("status clear ignored");
  property p_rearm;
    WR_I && ADDR_I == `UBRT_OFS_CTRL && WDATA_I[11] ##2 RD_I && ADDR_I == FL
      |=> !RDATA_O[8];
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("timeout kept after rearm");
endmodule : ubrt_props

bind ubrt_core ubrt_props u_props (.CLK_I, .RST_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .RXD_I, .TXD_O, .SCLK_I, .SCLK_O, .SCLK_OE_O);

// ===== dv/ubrt_peer.sv
// Far serial peer: sends frames to the core, captures its frames.
// Assumes one bit lasts BIT_NS on both lines.
module ubrt_peer #(
  parameter int BIT_NS = 640
) (
  input wire logic txd_i,
  output logic rxd_o,
  output logic sclk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] got = 11'h0;
  int n_got = 0;
  initial sclk_o = 1'b0;
  initial rxd_o = 1'b1;
  // Frame goes out LSB first, then line idles high
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      rxd_o = f[i];
      #(BIT_NS);
    end
    rxd_o = 1'b1;
  endtask : send
  task automatic glitch(input int ns);
    rxd_o = 1'b0;
    #(ns);
    rxd_o = 1'b1;
  endtask : glitch
  // Mid-bit capture; single frames only
  always @(negedge txd_i) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 11; i++) begin
      got[i] = txd_i;
      #(BIT_NS);
    end
    n_got++;
  end
endmodule : ubrt_peer

// ===== dv/tb_usart_baud_rx_tx_core.sv
// Self-checking bench of the serial channel core.
// Assumes divisor 1: sixteen clocks a bit on both lines.
`include "ubrt_consts.svh"
module tb_usart_baud_rx_tx_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] FL = `UBRT_OFS_FLAGS;
  localparam logic [5:0] RX = `UBRT_OFS_RXHOLD;
  localparam logic [5:0] MD = `UBRT_OFS_MODE;
  localparam logic [5:0] CT = `UBRT_OFS_CTRL;
  localparam logic [31:0] MODE8 = 32'h0004_0003;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic rxd, txd, sclk_in, sclk_out, sclk_oe;
  logic [4:0] pbit = 5'b11001;
  logic [31:0] fr;
  int n_sclk = 0;
  int n0 = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  // Bit clock rises seen on the pin
  always @(posedge sclk_out) n_sclk++;
  ubrt_core uut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd),
    .SCLK_I(sclk_in), .SCLK_O(sclk_out), .SCLK_OE_O(sclk_oe));
  ubrt_peer #(.BIT_NS(640)) peer (.txd_i(txd), .rxd_o(rxd),
    .sclk_o(sclk_in));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Each access takes two cycles, strobe then quiet
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rchk(input logic [5:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata & m);
    @(posedge clk);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // A wait that runs out shows up as a missing frame
  task automatic txwait(input int n);
    for (int i = 0; i < 1000 && peer.n_got < n; i++) @(posedge clk);
    chk("frames", n, peer.n_got);
  endtask : txwait
  task automatic rx(input logic [7:0] d, input logic pb, input logic sb);
    // Line moves off the sampling edge
    @(negedge clk);
    peer.send({sb, pb, d, 1'b0});
    idle(10);
  endtask : rx
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial begin
    idle(5);
    rst <= 1'b0;
    idle(1);
    rchk(FL, 32'hFFFF_FFFF, 32'h202, "flags");
    wr(MD, 32'h0004_0023);
    chk("pin drive", 32'h0, {31'h0, sclk_oe});
    wr(`UBRT_OFS_DIVISOR, 32'h1);
    rchk(`UBRT_OFS_DIVISOR, 32'hFFFF, 32'h1, "divisor");
    $display("test setup done");
    for (int t = 0; t < 5; t++) begin
      wr(MD, MODE8 | (t << 8));
      chk("pin drive", 32'h1, {31'h0, sclk_oe});
      wr(`UBRT_OFS_TXHOLD, 32'hA7);
      rchk(FL, 32'h200, 32'h0, "tx busy");
      txwait(t + 1);
      fr = {21'h0, 1'b1, pbit[t], 8'hA7, 1'b0};
      chk("frame", fr, {21'h0, peer.got});
      rchk(FL, 32'h202, 32'h202, "tx done");
    end
    $display("test transmit done");
    // Clocked mode, sixteen clocks a bit, two gap bits
    wr(`UBRT_OFS_DIVISOR, 32'h10);
    wr(`UBRT_OFS_GAP, 32'h2);
    wr(MD, MODE8 | 32'h80);
    wr(`UBRT_OFS_TXHOLD, 32'hA7);
    txwait(6);
    fr = {21'h0, 1'b1, pbit[0], 8'hA7, 1'b0};
    chk("clocked frame", fr, {21'h0, peer.got});
    rchk(FL, 32'h200, 32'h0, "gap busy");
    idle(48);
    rchk(FL, 32'h200, 32'h200, "gap done");
    n0 = n_sclk;
    idle(160);
    chk("bit clocks", 32'hA, n_sclk - n0);
    rx(8'h5A, 1'b0, 1'b1);
    rchk(RX, 32'hFF, 32'h5A, "clocked rx");
    wr(`UBRT_OFS_DIVISOR, 32'h1);
    $display("test clocked done");
    wr(MD, MODE8);
    rx(8'h5A, 1'b0, 1'b1);
    rchk(FL, 32'h1E1, 32'h001, "rx full");
    rchk(RX, 32'hFF, 32'h5A, "rx data");
    rchk(FL, 32'h81, 32'h0, "rx read");
    rx(8'h5A, 1'b1, 1'b1);
    rchk(FL, 32'h81, 32'h81, "check err");
    rchk(RX, 32'hFF, 32'h5A, "rx data");
    rchk(FL, 32'h80, 32'h0, "check clr");
    rx(8'h33, 1'b0, 1'b1);
    rx(8'h33, 1'b0, 1'b1);
    rchk(FL, 32'h21, 32'h21, "overrun");
    wr(CT, 32'h100);
    rchk(FL, 32'h60, 32'h0, "status clr");
    rchk(RX, 32'hFF, 32'h33, "rx data");
    rx(8'h5A, 1'b0, 1'b0);
    rchk(FL, 32'h40, 32'h40, "framing");
    wr(CT, 32'h100);
    rchk(RX, 32'hFF, 32'h5A, "rx data");
    // Low stop leaves eight low ticks: a start that reads all ones
    idle(160);
    rchk(RX, 32'hFF, 32'hFF, "after low stop");
    @(negedge clk);
    peer.glitch(230);
    idle(40);
    rchk(FL, 32'h1, 32'h0, "glitch");
    $display("test receive done");
    wr(`UBRT_OFS_IDLELIM, 32'h1);
    wr(CT, 32'h800);
    rx(8'h5A, 1'b0, 1'b1);
    rchk(FL, 32'h101, 32'h001, "idle early");
    idle(80);
    rchk(FL, 32'h100, 32'h100, "idle late");
    wr(CT, 32'h800);
    rchk(FL, 32'h100, 32'h0, "rearm clr");
    idle(120);
    rchk(FL, 32'h100, 32'h0, "rearmed");
    $display("test idle done");
    summarize();
  end
  // Watchdog: the tests need well under 10000 clocks
  initial begin
    #1_000_000;
    n_mismatch++;
    summarize();
  end
endmodule : tb_usart_baud_rx_tx_core
